/* logic/timer_two_pkg.sv */
// constants for the timer two, uart clock select and power control register block
// assumes a classic wishbone slave with 32-bit data, eight-bit registers in the low byte, 16-bit reload and count in the low half
package timer_two_pkg;
    localparam logic [7:0] baud_reload_off = 8'h9a;
    localparam logic [7:0] timer_two_control_off = 8'hc8;
    localparam logic [7:0] power_control_off = 8'h87;
    localparam logic [7:0] count_off = 8'hcc;
    localparam logic [7:0] reload_off = 8'hca;
    localparam logic [7:0] serial_ctl_off = 8'h98;
    localparam logic [7:0] baud_run_off = 8'h9b;
    localparam logic [7:0] baud_reload_rst = 8'h00;
    localparam logic [7:0] timer_two_control_rst = 8'h00;
    localparam logic [7:0] power_control_rst = 8'h00;
    localparam logic [7:0] serial_ctl_rst = 8'h00;
    localparam logic [15:0] count_rst = 16'h0000;
    // control register bit positions
    localparam int overflow_bit = 7;
    localparam int ext_flag_bit = 6;
    localparam int rx_sel_bit = 5;
    localparam int tx_sel_bit = 4;
    localparam int ext_en_bit = 3;
    localparam int run_bit = 2;
    localparam int counter_sel_bit = 1;
    localparam int capture_sel_bit = 0;
    // power control bit positions
    localparam int doubling_bit = 7;
    localparam int fe_access_bit = 6;
    localparam int reserved_bit = 5;
    localparam int cold_start_bit = 4;
    localparam int gflag_one_bit = 3;
    localparam int gflag_zero_bit = 2;
    localparam int pdown_bit = 1;
    localparam int idle_bit = 0;
    // baud generator
    localparam int baud_div_base = 32;
    localparam int slow_div = 6;
    localparam logic [7:0] reserved_read_val = 8'h00;
endpackage

/* logic/timer_two_power_ctrl.sv */
// timer two control, uart clock selection, baud reload and power control registers
// assumes a classic wishbone master on clk_i and asynchronous pins for trigger and count
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - eight bit baud reload register feeds the baud generator, resets to zero
// - external flag sets on enabled trigger falling edge, causing capture or reload when no uart select is set
// - external flag with interrupt enable requests the timer two interrupt
// - only software clears external flag
// - in modes 1 and 3 receive clock is timer two or timer one overflow
// - in modes 1 and 3 transmit clock is timer two or timer one overflow
// - counter select zero counts peripheral clock, one counts count pin falling edges
// - either uart select leaves overflow auto-reload only; the trigger then neither captures nor reloads
// - capture select zero reloads on overflow and trigger; one captures on trigger
// - doubling bit doubles the uart baud rate in modes 1, 2 and 3
// - frame access select picks mode bit or framing error flag at serial bit 7
// - cold start flag set at power-up, software may set or clear it
// - two general flags are plain software storage
// - power-down request enters power-down, cleared by reset
// - freeze request enters idle, cleared by interrupt or reset
// - bit 5 of power control is reserved and not stored
// - baud rate is 2^double times clock over 32, 256 minus reload, and 6 slow
// - framing error set on bad stop bit, cleared only by software
module timer_two_power_ctrl
    import timer_two_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic timer_two_trigger_pin_i,
    input wire logic timer_two_count_pin_i,
    input wire logic power_on_i,
    input wire logic timer_two_int_enable_i,
    input wire logic interrupt_taken_i,
    input wire logic [1:0] serial_mode_i,
    input wire logic timer_one_overflow_i,
    input wire logic stop_bit_bad_i,
    output logic timer_two_irq_o,
    output logic rx_clock_o,
    output logic tx_clock_o,
    output logic baud_tick_o,
    output logic baud_double_o,
    output logic idle_mode_o,
    output logic power_down_o
);
    logic [7:0] baud_reload_r, baud_reload_nxt;
    logic [7:0] timer_two_control_r, timer_two_control_nxt;
    logic [7:0] power_control_r, power_control_nxt;
    logic [15:0] count_r, count_nxt;
    logic [15:0] reload_r, reload_nxt;
    logic [15:0] capture_r, capture_nxt;
    logic [4:0] baud_run_r, baud_run_nxt;
    logic stop_error_r, stop_error_nxt;
    logic mode_bit_r, mode_bit_nxt;
    logic [11:0] presc_r, presc_nxt;
    logic [7:0] baud_cnt_r, baud_cnt_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic [2:0] pin_raw, pin_s1_r, pin_s2_r, pin_s3_r;
    logic [7:0] addr;
    logic wr;
    logic trig_fall, cnt_fall, pwr_rise, tick, overflow, uart_sel, ext_event, t2_ovf_pulse;
    logic baud_tick;
    logic [11:0] presc_top;

    assign addr = adr_i[9:2];
    assign wr = cyc_i && stb_i && we_i && sel_i[0] && !ack_r;
    // pin order: trigger, count, supply; the third flop only remembers the last level
    assign pin_raw = {power_on_i, timer_two_count_pin_i, timer_two_trigger_pin_i};
    assign trig_fall = pin_s3_r[0] && !pin_s2_r[0];
    assign cnt_fall = pin_s3_r[1] && !pin_s2_r[1];
    assign pwr_rise = pin_s2_r[2] && !pin_s3_r[2];

    // trigger and count idle high like pulled-up pins; resetting them high avoids a false edge
    localparam logic [2:0] pin_idle = 3'h3;
    for (genvar p = 0; p < 3; p++) begin : g_sync
        always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
                pin_s1_r[p] <= pin_idle[p];
                pin_s2_r[p] <= pin_idle[p];
                pin_s3_r[p] <= pin_idle[p];
            end else begin
                pin_s1_r[p] <= pin_raw[p];
                pin_s2_r[p] <= pin_s1_r[p];
                pin_s3_r[p] <= pin_s2_r[p];
            end
        end
    end

    assign uart_sel = timer_two_control_r[rx_sel_bit] || timer_two_control_r[tx_sel_bit];
    // slow generator divides by an extra six
    assign presc_top = baud_run_r[1] ? 12'(baud_div_base - 1) : 12'(baud_div_base * slow_div - 1);

    always_comb begin
        tick = timer_two_control_r[counter_sel_bit] ? cnt_fall : 1'b1;
        tick = tick && timer_two_control_r[run_bit];
        overflow = tick && (count_r == 16'hffff);
        ext_event = trig_fall && timer_two_control_r[ext_en_bit];
        t2_ovf_pulse = overflow;
    end

    always_comb begin
        baud_tick = 1'b0;
        presc_nxt = presc_r;
        baud_cnt_nxt = baud_cnt_r;
        if (baud_run_r[4]) begin
            // doubling halves the prescale
            if (presc_r >= (power_control_r[doubling_bit] ? (presc_top >> 1) : presc_top)) begin
                presc_nxt = 12'h000;
                if (baud_cnt_r == 8'hff) begin
                    baud_cnt_nxt = baud_reload_r;
                    baud_tick = 1'b1;
                end else begin
                    baud_cnt_nxt = baud_cnt_r + 8'h01;
                end
            end else begin
                presc_nxt = presc_r + 12'h001;
            end
        end
    end

    always_comb begin
        count_nxt = count_r;
        capture_nxt = capture_r;
        if (overflow) begin
            count_nxt = reload_r;
        end else if (tick) begin
            count_nxt = count_r + 16'h0001;
        end
        if (ext_event) begin
            if (timer_two_control_r[capture_sel_bit] && !uart_sel) begin
                capture_nxt = count_r;
            end else if (!uart_sel) begin
                count_nxt = reload_r;
            end
        end
        baud_reload_nxt = baud_reload_r;
        timer_two_control_nxt = timer_two_control_r;
        power_control_nxt = power_control_r;
        reload_nxt = reload_r;
        baud_run_nxt = baud_run_r;
        stop_error_nxt = stop_error_r;
        mode_bit_nxt = mode_bit_r;
        if (wr) begin
            case (addr)
                baud_reload_off: begin
                    baud_reload_nxt = dat_i[7:0];
                end
                timer_two_control_off: begin
                    timer_two_control_nxt = dat_i[7:0];
                end
                power_control_off: begin
                    power_control_nxt = dat_i[7:0];
                    power_control_nxt[reserved_bit] = 1'b0;
                end
                reload_off: begin
                    reload_nxt = dat_i[15:0];
                end
                baud_run_off: begin
                    baud_run_nxt = dat_i[4:0];
                end
                count_off: begin
                    count_nxt = dat_i[15:0];
                end
                serial_ctl_off: begin
                    if (power_control_r[fe_access_bit]) begin
                        stop_error_nxt = dat_i[7];
                    end else begin
                        mode_bit_nxt = dat_i[7];
                    end
                end
                default: ;
            endcase
        end
        // hardware sets win over a software clear in the same cycle
        if (t2_ovf_pulse && !uart_sel) begin
            timer_two_control_nxt[overflow_bit] = 1'b1;
        end
        if (ext_event) begin
            timer_two_control_nxt[ext_flag_bit] = 1'b1;
        end
        if (pwr_rise) begin
            power_control_nxt[cold_start_bit] = 1'b1;
        end
        if (stop_bit_bad_i) begin
            stop_error_nxt = 1'b1;
        end
        // a taken interrupt wakes the core even if software writes idle in that cycle
        if (interrupt_taken_i) begin
            power_control_nxt[idle_bit] = 1'b0;
        end
    end

    always_comb begin
        ack_nxt = cyc_i && stb_i && !ack_r;
        dat_nxt = dat_r;
        if (cyc_i && stb_i && !ack_r) begin
            case (addr)
                baud_reload_off: begin
                    dat_nxt = {24'h0, baud_reload_r};
                end
                timer_two_control_off: begin
                    dat_nxt = {24'h0, timer_two_control_r};
                end
                power_control_off: begin
                    dat_nxt = {24'h0, power_control_r[7:6], reserved_read_val[0], power_control_r[4:0]};
                end
                reload_off: begin
                    dat_nxt = {16'h0, reload_r};
                end
                count_off: begin
                    dat_nxt = {capture_r, count_r};
                end
                baud_run_off: begin
                    dat_nxt = {27'h0, baud_run_r};
                end
                serial_ctl_off: begin
                    dat_nxt = {24'h0, power_control_r[fe_access_bit] ? stop_error_r : mode_bit_r, 7'h0};
                end
                default: begin
                    dat_nxt = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            presc_r <= 12'h000;
            baud_cnt_r <= 8'h00;
        end else begin
            presc_r <= presc_nxt;
            baud_cnt_r <= baud_cnt_nxt;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            timer_two_control_r <= timer_two_control_rst;
            count_r <= count_rst;
            reload_r <= count_rst;
            capture_r <= count_rst;
        end else begin
            timer_two_control_r <= timer_two_control_nxt;
            count_r <= count_nxt;
            reload_r <= reload_nxt;
            capture_r <= capture_nxt;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            baud_reload_r <= baud_reload_rst;
            power_control_r <= power_control_rst;
            baud_run_r <= 5'h00;
            stop_error_r <= 1'b0;
            mode_bit_r <= 1'b0;
        end else begin
            baud_reload_r <= baud_reload_nxt;
            power_control_r <= power_control_nxt;
            baud_run_r <= baud_run_nxt;
            stop_error_r <= stop_error_nxt;
            mode_bit_r <= mode_bit_nxt;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    logic uart_var_mode;
    assign uart_var_mode = serial_mode_i == 2'd1 || serial_mode_i == 2'd3;
    assign ack_o = ack_r;
    assign dat_o = dat_r;
    // updown counting is not built, so the external flag always reaches the request
    assign timer_two_irq_o = timer_two_int_enable_i
        && (timer_two_control_r[overflow_bit] || timer_two_control_r[ext_flag_bit]);
    assign rx_clock_o = uart_var_mode
        && (timer_two_control_r[rx_sel_bit] ? t2_ovf_pulse : timer_one_overflow_i);
    assign tx_clock_o = uart_var_mode
        && (timer_two_control_r[tx_sel_bit] ? t2_ovf_pulse : timer_one_overflow_i);
    assign baud_tick_o = baud_tick;
    assign baud_double_o = power_control_r[doubling_bit] && serial_mode_i != 2'd0;
    assign idle_mode_o = power_control_r[idle_bit];
    assign power_down_o = power_control_r[pdown_bit];
endmodule

`default_nettype wire

/* dv/timer_two_power_asserts.sv */
// checker for bus timing and power control outputs
// assumes a bind onto timer_two_power_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module timer_two_power_asserts
    import timer_two_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic interrupt_taken_i,
    input wire logic timer_two_int_enable_i,
    input wire logic timer_two_irq_o,
    input wire logic baud_double_o,
    input wire logic idle_mode_o,
    input wire logic power_down_o
);
    wire logic req = cyc_i && stb_i && !ack_o;
    wire logic at_pwr = adr_i[9:2] == power_control_off;
    wire logic pw = req && we_i && sel_i[0] && at_pwr;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    AST_ACK_ONE: assert property (ack_o |=> !ack_o) else $error("ack wider than one cycle");
    AST_ACK_LAT: assert property (req |=> ack_o) else $error("request not acked next cycle");
    AST_IRQ_EN: assert property (timer_two_irq_o |-> timer_two_int_enable_i)
        else $error("irq without enable");
    AST_PD_SET: assert property (pw && dat_i[pdown_bit] |=> power_down_o)
        else $error("power-down not entered");
    AST_PD_HOLD: assert property ($fell(power_down_o) |-> $past(pw))
        else $error("power-down dropped without write");
    AST_IDLE_SET: assert property (pw && dat_i[idle_bit] && !interrupt_taken_i |=> idle_mode_o)
        else $error("idle not entered");
    AST_IDLE_CLR: assert property (interrupt_taken_i && !pw |=> !idle_mode_o)
        else $error("idle kept after interrupt");
    AST_DOUBLE: assert property (pw |=> baud_double_o == $past(dat_i[doubling_bit]))
        else $error("doubling output wrong");
    AST_RSV_RD: assert property (req && !we_i && at_pwr |=> !dat_o[reserved_bit])
        else $error("reserved bit read high");
endmodule
bind timer_two_power_ctrl timer_two_power_asserts u_chk (.clk_i, .reset_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .interrupt_taken_i, .timer_two_int_enable_i,
    .timer_two_irq_o, .baud_double_o, .idle_mode_o, .power_down_o);
`default_nettype wire

/* dv/pin_model.sv */
// model of the trigger and count pins driven from outside
// assumes one-cycle go strobes from the bench on clk_i
`timescale 1ns/1ps
`default_nettype none
module pin_model (
    input wire logic clk_i,
    input wire logic trig_go_i,
    input wire logic cnt_go_i,
    output logic trig_o,
    output logic cnt_o
);
    logic [1:0] low_r = 2'h0;
    logic [1:0] cnt_low_r = 2'h0;
    // idles high like a pulled-up pin; low long enough for the synchroniser
    always_ff @(posedge clk_i) begin
        low_r <= trig_go_i ? 2'h3 : low_r - {1'b0, |low_r};
        cnt_low_r <= cnt_go_i ? 2'h3 : cnt_low_r - {1'b0, |cnt_low_r};
    end
    assign trig_o = (low_r == 2'h0);
    assign cnt_o = (cnt_low_r == 2'h0);
endmodule
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the timer two and power control registers
// assumes the checker is bound and the pin model drives the trigger pin
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import timer_two_pkg::*;
    logic clk_i = 0, reset_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, go = 0, pon = 0;
    logic ien = 0, itk = 0, t1 = 0, cgo = 0, sbb = 0;
    logic [1:0] mode = 2'h1;
    logic [9:0] adr_i = '0;
    logic [3:0] sel_i = '0;
    logic [31:0] dat_i = '0, seed = 32'hff05c8b0;
    logic [31:0] q;
    logic [7:0] v;
    wire logic [31:0] dat_o;
    wire logic ack_o, irq, rxc, txc, tick, dbl, idle, pdn, pin, cpin;
    int errors = 0, cmp_count = 0, cy = 0;
    always #25 clk_i = ~clk_i;
    timer_two_power_ctrl uut (.clk_i, .reset_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .timer_two_trigger_pin_i(pin), .timer_two_count_pin_i(cpin),
        .power_on_i(pon), .timer_two_int_enable_i(ien), .interrupt_taken_i(itk),
        .serial_mode_i(mode), .timer_one_overflow_i(t1), .stop_bit_bad_i(sbb),
        .timer_two_irq_o(irq), .rx_clock_o(rxc), .tx_clock_o(txc), .baud_tick_o(tick),
        .baud_double_o(dbl), .idle_mode_o(idle), .power_down_o(pdn));
    pin_model u_pin (.clk_i, .trig_go_i(go), .cnt_go_i(cgo), .trig_o(pin), .cnt_o(cpin));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // the reserved bit is never stored
    function automatic logic [7:0] pwr_exp(input logic [7:0] w);
        return w & ~(8'h01 << reserved_bit);
    endfunction
    // clocks between baud ticks: 32, halved when doubling, times 256 minus reload
    function automatic int baud_per(input logic [7:0] r, input logic d);
        return (baud_div_base >> d) * (256 - r);
    endfunction
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // counts edges until the next baud tick has stood for a cycle
    task automatic wait_tick(output int n);
        n = 1;
        @(posedge clk_i);
        while (tick !== 1'b1 && n < 9000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 9000) begin
            errors++;
            give_verdict();
        end
    endtask
    // called just after a rising edge; holds the request until ack is sampled
    task automatic bus(input logic w, input logic [7:0] off, input logic [15:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        sel_i <= 4'h1;
        adr_i <= {off, 2'b00};
        dat_i <= {16'h0, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20) begin
            errors++;
            give_verdict();
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        foreach (v[i]) if (i < 3) begin
            bus(0, i == 0 ? baud_reload_off : i == 1 ? timer_two_control_off : power_control_off, 0);
            chk("reset value", 0, q);
        end
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            bus(1, baud_reload_off, seed[7:0]);
            bus(0, baud_reload_off, 0);
            chk("baud reload", seed[7:0], q);
            v = seed[15:8] | 8'h20;
            bus(1, power_control_off, v);
            bus(0, power_control_off, 0);
            chk("power control", pwr_exp(v), q);
            chk("outputs", {v[7], v[1:0]}, {dbl, pdn, idle});
        end
        $display("test registers done");
        bus(1, power_control_off, 8'h01);
        itk <= 1'b1;
        @(posedge clk_i);
        itk <= 1'b0;
        bus(0, power_control_off, 0);
        chk("idle cleared", 0, {q[0], idle});
        pon <= 1'b1;
        repeat (6) bus(0, power_control_off, 0);
        chk("cold start", 1, q[cold_start_bit]);
        bus(1, power_control_off, 0);
        bus(0, power_control_off, 0);
        chk("cold start cleared", 0, q);
        $display("test power done");
        bus(1, reload_off, 16'h1234);
        bus(1, timer_two_control_off, 8'h08);
        ien <= 1'b1;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        for (int n = 0; n < 20 && irq !== 1'b1; n++) @(posedge clk_i);
        chk("irq", 1, irq);
        bus(0, timer_two_control_off, 0);
        chk("external flag", 8'h48, q);
        bus(0, count_off, 0);
        chk("trigger reload", 32'h0000_1234, q);
        ien <= 1'b0;
        @(negedge clk_i);
        chk("irq masked", 0, irq);
        @(posedge clk_i);
        bus(1, timer_two_control_off, 0);
        bus(0, timer_two_control_off, 0);
        chk("flag cleared", 0, q);
        for (int m = 1; m < 4; m += 2) begin
            mode <= m[1:0];
            t1 <= 1'b1;
            @(negedge clk_i);
            chk("uart clocks", 2'h3, {rxc, txc});
            @(posedge clk_i);
            t1 <= 1'b0;
            @(negedge clk_i);
            chk("uart clocks idle", 0, {rxc, txc});
            @(posedge clk_i);
        end
        bus(1, count_off, 16'h0abc);
        bus(1, timer_two_control_off, 8'h09);
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (8) @(posedge clk_i);
        bus(0, count_off, 0);
        chk("capture", 32'h0abc_0abc, q);
        bus(1, count_off, 16'h0010);
        bus(1, timer_two_control_off, 8'h06);
        repeat (3) begin
            cgo <= 1'b1;
            @(posedge clk_i);
            cgo <= 1'b0;
            repeat (7) @(posedge clk_i);
        end
        bus(1, timer_two_control_off, 0);
        bus(0, count_off, 0);
        chk("count pin", 16'h0013, q[15:0]);
        bus(1, count_off, 16'hfff0);
        bus(1, timer_two_control_off, 8'h04);
        repeat (30) @(posedge clk_i);
        bus(0, timer_two_control_off, 0);
        chk("overflow flag", 8'h84, q);
        bus(1, timer_two_control_off, 0);
        bus(0, count_off, 0);
        chk("overflow reload", 1, q[15:0] - 16'h1234 < 16'd40);
        v = q[7:0];
        bus(0, count_off, 0);
        chk("count held", v, q[7:0]);
        bus(1, count_off, 16'hfff0);
        bus(1, timer_two_control_off, 8'h34);
        for (cy = 0; cy < 40 && rxc !== 1'b1; cy++) @(posedge clk_i);
        chk("timer two uart clocks", 2'h3, {rxc, txc});
        bus(0, timer_two_control_off, 0);
        chk("no overflow flag", 8'h34, q);
        bus(1, timer_two_control_off, 0);
        bus(0, count_off, 0);
        chk("auto reload", 1, q[15:0] - 16'h1234 < 16'd40);
        $display("test counter done");
        bus(1, power_control_off, 8'h40);
        sbb <= 1'b1;
        @(posedge clk_i);
        sbb <= 1'b0;
        bus(0, serial_ctl_off, 0);
        chk("framing error", 8'h80, q);
        bus(1, serial_ctl_off, 0);
        bus(0, serial_ctl_off, 0);
        chk("framing cleared", 0, q);
        bus(1, power_control_off, 0);
        bus(1, serial_ctl_off, 8'h80);
        bus(0, serial_ctl_off, 0);
        chk("mode bit", 8'h80, q);
        bus(1, power_control_off, 8'h40);
        bus(0, serial_ctl_off, 0);
        chk("frame view", 0, q);
        $display("test serial done");
        bus(1, baud_reload_off, 8'hfe);
        bus(1, baud_run_off, 8'h12);
        wait_tick(cy);
        wait_tick(cy);
        chk("baud period", baud_per(8'hfe, 1'b0), cy);
        bus(1, power_control_off, 8'h80);
        wait_tick(cy);
        wait_tick(cy);
        chk("double period", baud_per(8'hfe, 1'b1), cy);
        $display("test baud done");
        bus(1, power_control_off, 8'h03);
        chk("low power", 2'h3, {pdn, idle});
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        @(negedge clk_i);
        chk("reset clears", 0, {pdn, idle});
        @(posedge clk_i);
        bus(0, power_control_off, 0);
        chk("reset clears reg", 0, q[1:0]);
        $display("test reset done");
        bus(0, 8'h10, 0);
        chk("unmapped", 0, q);
        $display("test timer done");
        give_verdict();
    end
endmodule
`default_nettype wire
